// ==== fms_fuse_sequencer.sv ====
// automatic program and read-back sequencer with its register file
`timescale 1ns/1ps
// Notes on behaviour
// - array has 125 rows, two 20-bit words per row.
// - each word holds 16 payload bits and 4 check bits.
// - finished programming sets a pollable completion bit.
// - start address bits 15:8 select first array location.
// - length bits 7:0 give number of data registers transferred.
// - programming 102 words takes about 500 ms before completion.
// - writing 1 to control bit 0 starts automatic programming.
// - control bit 1 sets when programming ends; host polls it.
// - control bit 4 starts read; bit 5 sets when read ends.
// - read words appear in the data register range.
// - register access keeps working in low-power states.
module fms_fuse_sequencer
    import fms_pkg::*;
#(
    parameter logic [BURN_CNT_W-1:0] BURN_CYCLES = BURN_CNT_W'(FUSE_BURN_TIME_US * 1000 / CLK_PERIOD_NS)
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port from the two-wire serial interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // sensor status
    output logic             soft_standby,
    output logic             pll_bypass,
    output logic             core_clk_en,
    output logic             fuse_busy
);
    fms_fuse_if fuse ();

    fms_fuse_array u_array (
        .clk_sys (clk_sys),
        .rst     (rst),
        .fuse    (fuse)
    );

    fms_state_t            state,   next_state;
    logic [ADDR_W-1:0]     idx,     next_idx;
    logic [BURN_CNT_W-1:0] cnt,     next_cnt;
    logic [15:0]           run_ctrl, next_run_ctrl;
    logic [15:0]           len_reg,  next_len_reg;
    logic [15:0]           start_reg, next_start_reg;
    logic [15:0]           cfg_reg,  next_cfg_reg;
    logic [15:0]           mode_reg, next_mode_reg;
    logic [15:0]           pll_reg,  next_pll_reg;
    logic                  wr_end,  next_wr_end;
    logic                  rd_end,  next_rd_end;
    logic                  ecc_err, next_ecc_err;
    logic [15:0]           rdata,   next_rdata;
    logic [PAYLOAD_W-1:0]  data_regs [DATA_REGS];
    logic                  dw_en;
    logic [ADDR_W-1:0]     dw_idx;
    logic [PAYLOAD_W-1:0]  dw_val;

    logic                  sw_reset_hit;
    logic                  data_hit;
    logic [ADDR_W-1:0]     host_idx;
    logic [ADDR_W-1:0]     len;
    logic [ADDR_W-1:0]     last_idx;
    logic                  ecc_on;
    logic [PAYLOAD_W-1:0]  stage_word;
    logic [PAYLOAD_W-1:0]  got_payload;
    logic [CHECK_W-1:0]    got_check;
    logic                  ctl_write;

    assign sw_reset_hit = reg_wr && reg_addr == OFS_SW_RESET && reg_wdata[7:0] == SW_RESET_CMD;
    assign data_hit     = reg_addr >= OFS_DATA_BASE && reg_addr <= OFS_DATA_LAST && !reg_addr[0];
    assign host_idx     = reg_addr[DATA_IDX_HI:DATA_IDX_LO];
    assign len          = len_reg[LEN_HI:LEN_LO];
    assign last_idx     = len - 8'h01;
    assign ecc_on       = !mode_reg[MODE_ECC_DIS];
    assign stage_word   = data_regs[idx];
    assign got_payload  = fuse.rdata[PAYLOAD_W-1:0];
    assign got_check    = fuse.rdata[FUSE_WORD_W-1:PAYLOAD_W];
    assign ctl_write    = reg_wr && reg_addr == OFS_SEQ_CTRL;

    // array requests
    assign fuse.addr   = start_reg[START_HI:START_LO] + idx;
    assign fuse.wr_req = state == FMS_WR_BURN && cnt == BURN_CYCLES - 1'b1;
    assign fuse.rd_req = state == FMS_RD_ISSUE;
    // check bits are written as zero when correction is switched off
    assign fuse.wdata  = {ecc_on ? fms_check(stage_word) : {CHECK_W{1'b0}}, stage_word};

    always_comb begin
        next_state     = state;
        next_idx       = idx;
        next_cnt       = cnt;
        next_run_ctrl  = run_ctrl;
        next_len_reg   = len_reg;
        next_start_reg = start_reg;
        next_cfg_reg   = cfg_reg;
        next_mode_reg  = mode_reg;
        next_pll_reg   = pll_reg;
        next_wr_end    = wr_end;
        next_rd_end    = rd_end;
        next_ecc_err   = ecc_err;
        next_rdata     = rdata;
        dw_en          = 1'b0;
        dw_idx         = host_idx;
        dw_val         = reg_wdata;

        // sequence engine
        case (state)
            FMS_WR_BURN: begin
                next_cnt = cnt + 1'b1;
                if (fuse.wr_req) begin
                    next_cnt = '0;
                    next_idx = idx + 1'b1;
                    if (idx == last_idx) begin
                        next_state  = FMS_IDLE;
                        next_wr_end = 1'b1;
                    end
                end
            end
            FMS_RD_ISSUE: begin
                next_state = FMS_RD_WAIT;
            end
            FMS_RD_WAIT: begin
                if (fuse.ack) begin
                    dw_en  = 1'b1;
                    dw_idx = idx;
                    dw_val = got_payload;
                    if (ecc_on && fms_check(got_payload) != got_check) begin
                        next_ecc_err = 1'b1;
                    end
                    next_idx = idx + 1'b1;
                    if (idx == last_idx) begin
                        next_state  = FMS_IDLE;
                        next_rd_end = 1'b1;
                    end else begin
                        next_state = FMS_RD_ISSUE;
                    end
                end
            end
            default: begin
                // starts are ignored while a sequence runs or access is off
                if (ctl_write && mode_reg[MODE_ACCESS_EN]) begin
                    next_idx = '0;
                    next_cnt = '0;
                    if (reg_wdata[CTL_WR_START]) begin
                        next_wr_end = len == '0;
                        if (len != '0) begin
                            next_state = FMS_WR_BURN;
                        end
                    end else if (reg_wdata[CTL_RD_START]) begin
                        next_rd_end  = len == '0;
                        next_ecc_err = 1'b0;
                        if (len != '0) begin
                            next_state = FMS_RD_ISSUE;
                        end
                    end
                end
            end
        endcase

        // host register writes
        if (reg_wr) begin
            if (reg_addr == OFS_RUN_CTRL) begin
                next_run_ctrl = reg_wdata;
            end else if (reg_addr == OFS_LEN) begin
                next_len_reg = reg_wdata;
            end else if (reg_addr == OFS_START) begin
                next_start_reg = reg_wdata;
            end else if (reg_addr == OFS_CFG) begin
                next_cfg_reg = reg_wdata;
            end else if (reg_addr == OFS_MODE) begin
                next_mode_reg = reg_wdata;
            end else if (reg_addr == OFS_PLL) begin
                next_pll_reg = reg_wdata;
            end else if (data_hit && !dw_en) begin
                dw_en = 1'b1;
            end
        end

        // host register reads, one cycle latency
        if (reg_rd) begin
            if (reg_addr == OFS_RUN_CTRL) begin
                next_rdata = run_ctrl;
            end else if (reg_addr == OFS_SEQ_CTRL) begin
                next_rdata = '0;
                next_rdata[CTL_WR_END]  = wr_end;
                next_rdata[CTL_RD_END]  = rd_end;
                next_rdata[CTL_ECC_ERR] = ecc_err;
                next_rdata[CTL_BUSY]    = state != FMS_IDLE;
            end else if (reg_addr == OFS_LEN) begin
                next_rdata = len_reg;
            end else if (reg_addr == OFS_START) begin
                next_rdata = start_reg;
            end else if (reg_addr == OFS_CFG) begin
                next_rdata = cfg_reg;
            end else if (reg_addr == OFS_MODE) begin
                next_rdata = mode_reg;
            end else if (reg_addr == OFS_PLL) begin
                next_rdata = pll_reg;
            end else if (data_hit) begin
                next_rdata = data_regs[host_idx];
            end else begin
                next_rdata = '0;
            end
        end

        // software reset aborts any sequence and restores the control registers
        if (sw_reset_hit) begin
            next_state     = FMS_IDLE;
            next_idx       = '0;
            next_cnt       = '0;
            next_run_ctrl  = REG_RESET;
            next_len_reg   = REG_RESET;
            next_start_reg = REG_RESET;
            next_cfg_reg   = REG_RESET;
            next_mode_reg  = REG_RESET;
            next_pll_reg   = REG_RESET;
            next_wr_end    = 1'b0;
            next_rd_end    = 1'b0;
            next_ecc_err   = 1'b0;
            dw_en          = 1'b0;
        end
    end

    // clk_sys is never gated, so the register port answers in every power state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state     <= FMS_IDLE;
            idx       <= '0;
            cnt       <= '0;
            run_ctrl  <= REG_RESET;
            len_reg   <= REG_RESET;
            start_reg <= REG_RESET;
            cfg_reg   <= REG_RESET;
            mode_reg  <= REG_RESET;
            pll_reg   <= REG_RESET;
            wr_end    <= 1'b0;
            rd_end    <= 1'b0;
            ecc_err   <= 1'b0;
            rdata     <= REG_RESET;
        end else begin
            state     <= next_state;
            idx       <= next_idx;
            cnt       <= next_cnt;
            run_ctrl  <= next_run_ctrl;
            len_reg   <= next_len_reg;
            start_reg <= next_start_reg;
            cfg_reg   <= next_cfg_reg;
            mode_reg  <= next_mode_reg;
            pll_reg   <= next_pll_reg;
            wr_end    <= next_wr_end;
            rd_end    <= next_rd_end;
            ecc_err   <= next_ecc_err;
            rdata     <= next_rdata;
        end
    end

    // staging and read-back words; sequencer wins a same-cycle clash
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DATA_REGS; i++) begin
                data_regs[i] <= '0;
            end
        end else if (dw_en) begin
            data_regs[dw_idx] <= dw_val;
        end
    end

    assign reg_rdata    = rdata;
    assign soft_standby = !run_ctrl[RUN_STREAM_BIT];
    assign core_clk_en  = run_ctrl[RUN_STREAM_BIT];
    assign pll_bypass   = pll_reg[PLL_BYPASS_BIT];
    assign fuse_busy    = state != FMS_IDLE;
endmodule : fms_fuse_sequencer

// ==== fms_pkg.sv ====
// constants, register map and types for the fuse memory sequencer
package fms_pkg;
    // register offsets
    localparam logic [15:0] OFS_SW_RESET  = 16'h0103;
    localparam logic [15:0] OFS_RUN_CTRL  = 16'h301a;
    localparam logic [15:0] OFS_SEQ_CTRL  = 16'h304a;
    localparam logic [15:0] OFS_LEN       = 16'h304c;
    localparam logic [15:0] OFS_START     = 16'h3050;
    localparam logic [15:0] OFS_CFG       = 16'h3052;
    localparam logic [15:0] OFS_MODE      = 16'h3054;
    localparam logic [15:0] OFS_PLL       = 16'h3064;
    localparam logic [15:0] OFS_DATA_BASE = 16'h3800;
    localparam logic [15:0] OFS_DATA_LAST = 16'h39fe;
    // field positions
    localparam int CTL_WR_START   = 0;
    localparam int CTL_WR_END     = 1;
    localparam int CTL_RD_START   = 4;
    localparam int CTL_RD_END     = 5;
    localparam int CTL_ECC_ERR    = 6;
    localparam int CTL_BUSY       = 7;
    localparam int MODE_ACCESS_EN = 8;
    localparam int MODE_ECC_DIS   = 9;
    localparam int PLL_BYPASS_BIT = 9;
    localparam int RUN_STREAM_BIT = 2;
    localparam int START_HI       = 15;
    localparam int START_LO       = 8;
    localparam int LEN_HI         = 7;
    localparam int LEN_LO         = 0;
    localparam int DATA_IDX_HI    = 8;
    localparam int DATA_IDX_LO    = 1;
    // reset values and commands
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [7:0]  SW_RESET_CMD  = 8'h01;
    // array geometry
    localparam int FUSE_ROWS     = 125;
    localparam int WORDS_PER_ROW = 2;
    localparam int FUSE_WORDS    = FUSE_ROWS * WORDS_PER_ROW;
    localparam int PAYLOAD_W     = 16;
    localparam int CHECK_W       = 4;
    localparam int FUSE_WORD_W   = PAYLOAD_W + CHECK_W;
    localparam int NIBBLE_W      = PAYLOAD_W / CHECK_W;
    localparam int ADDR_W        = 8;
    localparam int DATA_REGS     = 256;
    // timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int FUSE_BURN_TIME_US = 4900;
    localparam int BURN_CNT_W        = 20;

    typedef enum logic [1:0] {
        FMS_IDLE,
        FMS_WR_BURN,
        FMS_RD_ISSUE,
        FMS_RD_WAIT
    } fms_state_t;

    function automatic logic [CHECK_W-1:0] fms_check(input logic [PAYLOAD_W-1:0] d);
        logic [CHECK_W-1:0] c;
        for (int k = 0; k < CHECK_W; k++) begin
            c[k] = ^d[k*NIBBLE_W +: NIBBLE_W];
        end
        return c;
    endfunction : fms_check
endpackage : fms_pkg

// ==== fms_fuse_if.sv ====
// link between the sequencer and the fuse cell array
`timescale 1ns/1ps
interface fms_fuse_if;
    import fms_pkg::*;
    logic                   wr_req;
    logic                   rd_req;
    logic [ADDR_W-1:0]      addr;
    logic [FUSE_WORD_W-1:0] wdata;
    logic [FUSE_WORD_W-1:0] rdata;
    logic                   ack;
    modport seq   (output wr_req, output rd_req, output addr, output wdata, input rdata, input ack);
    modport array (input wr_req, input rd_req, input addr, input wdata, output rdata, output ack);
endinterface : fms_fuse_if

// ==== fms_fuse_array.sv ====
// one-time programmable cell array, 125 rows of two 20-bit words
`timescale 1ns/1ps
module fms_fuse_array
    import fms_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // sequencer side
    fms_fuse_if.array fuse
);
    logic [FUSE_WORD_W-1:0] cells [FUSE_WORDS];
    logic                   ack;
    logic                   next_ack;
    logic [FUSE_WORD_W-1:0] rdata;
    logic [FUSE_WORD_W-1:0] next_rdata;
    logic                   in_range;

    // unprogrammed anti-fuses read as zero
    initial begin
        for (int i = 0; i < FUSE_WORDS; i++) begin
            cells[i] = '0;
        end
    end

    assign in_range = ({1'b0, fuse.addr} < 9'(FUSE_WORDS));

    always_comb begin
        next_ack   = fuse.wr_req | fuse.rd_req;
        next_rdata = rdata;
        if (fuse.rd_req) begin
            next_rdata = in_range ? cells[fuse.addr] : '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    // burned cells never return to zero; no reset, the array is nonvolatile
    always_ff @(posedge clk_sys) begin
        if (fuse.wr_req && in_range) begin
            cells[fuse.addr] <= cells[fuse.addr] | fuse.wdata;
        end
    end

    assign fuse.ack   = ack;
    assign fuse.rdata = rdata;
endmodule : fms_fuse_array

// ==== fms_seq_props.sv ====
// port-level checks for the fuse sequencer
`timescale 1ns/1ps
module fms_seq_props
    import fms_pkg::*;
#(
    parameter logic [BURN_CNT_W-1:0] BURN_CYCLES = 20'h0_0006
)(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // status
    input wire logic        soft_standby,
    input wire logic        pll_bypass,
    input wire logic        core_clk_en,
    input wire logic        fuse_busy
);
    logic       mode_en;
    logic [7:0] len_q;
    logic       op_act;
    logic       op_wr;
    int         busy_cnt;
    int         exp_cnt;
    logic       ctl_wr;
    logic       start_ok;
    logic       swrst;
    assign ctl_wr   = reg_wr && reg_addr == OFS_SEQ_CTRL;
    assign swrst    = reg_wr && reg_addr == OFS_SW_RESET && reg_wdata[7:0] == SW_RESET_CMD;
    assign start_ok = ctl_wr && (reg_wdata[CTL_WR_START] || reg_wdata[CTL_RD_START]) && !fuse_busy && mode_en;
    // read words take two cycles each: issue, then registered array answer with store
    assign exp_cnt  = op_wr ? int'(len_q) * int'(BURN_CYCLES) : 2 * int'(len_q);
    // soft reset aborts, so its sequence is dropped from the length check
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst || swrst) begin
            mode_en  <= 1'b0;
            len_q    <= 8'h00;
            op_act   <= 1'b0;
            op_wr    <= 1'b0;
            busy_cnt <= 0;
        end else begin
            if (reg_wr && reg_addr == OFS_MODE) mode_en <= reg_wdata[MODE_ACCESS_EN];
            if (reg_wr && reg_addr == OFS_LEN) len_q <= reg_wdata[LEN_HI:LEN_LO];
            if (start_ok && len_q != 8'h00) begin
                op_act   <= 1'b1;
                op_wr    <= reg_wdata[CTL_WR_START];
                busy_cnt <= 0;
            end else if (fuse_busy) begin
                busy_cnt <= busy_cnt + 1;
            end else begin
                op_act <= 1'b0;
            end
        end
    end
    AST_START_BUSY: assert property (@(posedge clk_sys) disable iff (rst)
        start_ok && len_q != 8'h00 |=> fuse_busy) else $error("accepted start did not raise busy");
    AST_START_REFUSED: assert property (@(posedge clk_sys) disable iff (rst)
        ctl_wr && !mode_en && !fuse_busy |=> !fuse_busy) else $error("start taken while access disabled");
    AST_SEQ_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(fuse_busy) && op_act |-> busy_cnt inside {[exp_cnt - 1:exp_cnt + 2]})
        else $error("sequence length wrong");
    AST_END_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == OFS_SEQ_CTRL && fuse_busy && op_act |=>
        (op_wr ? reg_rdata[CTL_WR_END] : reg_rdata[CTL_RD_END]) == 1'b0) else $error("end flag set while busy");
    AST_BUSY_STATUS: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == OFS_SEQ_CTRL |=> reg_rdata[CTL_BUSY] == $past(fuse_busy))
        else $error("status busy bit wrong");
    AST_SWRST_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == OFS_SW_RESET |=> reg_rdata == 16'h0000) else $error("reset register not zero");
    AST_ODD_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr >= OFS_DATA_BASE && reg_addr <= OFS_DATA_LAST && reg_addr[0]
        |=> reg_rdata == 16'h0000) else $error("odd window address not zero");
    AST_RUN_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == OFS_RUN_CTRL |=> core_clk_en == $past(reg_wdata[RUN_STREAM_BIT])
        && soft_standby == !core_clk_en) else $error("run control outputs wrong");
    AST_PLL_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == OFS_PLL |=> pll_bypass == $past(reg_wdata[PLL_BYPASS_BIT]))
        else $error("pll bypass wrong");
    AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd && !(reg_wr && reg_addr == OFS_SW_RESET) |=> $stable(reg_rdata)) else $error("read data moved");
endmodule : fms_seq_props

bind fms_fuse_sequencer fms_seq_props #(.BURN_CYCLES(BURN_CYCLES)) fms_seq_props_i (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .soft_standby(soft_standby),
    .pll_bypass(pll_bypass), .core_clk_en(core_clk_en), .fuse_busy(fuse_busy));

// ==== fms_host_model.sv ====
// register port master standing in for the serial host
`timescale 1ns/1ps
module fms_host_model (
    // clock
    input  wire logic        clk_sys,
    // register port
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // released bus shows inverted values so stale data cannot pass
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
endmodule : fms_host_model

// ==== tb_fuse_memory_auto_sequencer.sv ====
// self-checking bench for the fuse sequencer against an integer model
`timescale 1ns/1ps
module tb_fuse_memory_auto_sequencer;
    import fms_pkg::*;
    localparam logic [BURN_CNT_W-1:0] BURN = 20'h0_0006;
    localparam int LIMIT = 20000;
    logic        clk_sys;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        soft_standby;
    logic        pll_bypass;
    logic        core_clk_en;
    logic        fuse_busy;
    logic [15:0] rd_v;
    logic [15:0] v;
    logic        wr_end;
    logic        rd_end;
    int          fails;
    int          check_count;
    int          cyc;
    int          seed;
    int          fuse[FUSE_WORDS];
    int          dreg[DATA_REGS];
    logic [15:0] regs[10] = '{OFS_RUN_CTRL, OFS_LEN, OFS_START, OFS_CFG, OFS_MODE, OFS_PLL,
                              16'h3802, OFS_SW_RESET, 16'h3000, 16'h3803};
    logic [15:0] msk[10]  = '{16'hffff, 16'h00ff, 16'hff00, 16'hffff, 16'h0300, 16'h0200,
                              16'hffff, 16'h0000, 16'h0000, 16'h0000};

    fms_fuse_sequencer #(.BURN_CYCLES(BURN)) fms_fuse_sequencer_i (
        .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .soft_standby(soft_standby),
        .pll_bypass(pll_bypass), .core_clk_en(core_clk_en), .fuse_busy(fuse_busy));
    fms_host_model fms_host_model_i (
        .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_pin

    task automatic run_seq(input logic wr, input int st, input int n);
        int k;
        int a;
        fms_host_model_i.wr(OFS_START, 16'(st << 8));
        fms_host_model_i.wr(OFS_LEN, 16'(n));
        fms_host_model_i.wr(OFS_CFG, wr ? 16'h2504 : 16'h2704);
        fms_host_model_i.wr(OFS_SEQ_CTRL, wr ? 16'h0001 : 16'h0010);
        // the other start while busy must be ignored
        fms_host_model_i.wr(OFS_SEQ_CTRL, wr ? 16'h0010 : 16'h0001);
        if (wr) wr_end = 1'b0;
        else rd_end = 1'b0;
        fms_host_model_i.rd(OFS_SEQ_CTRL, rd_v);
        chk_reg("ctrl busy", {8'h00, 1'b1, 1'b0, rd_end, 3'b000, wr_end, 1'b0}, rd_v);
        k = 0;
        while (rd_v[CTL_BUSY] !== 1'b0 && k < 400) begin
            fms_host_model_i.rd(OFS_SEQ_CTRL, rd_v);
            k++;
        end
        for (int i = 0; i < n; i++) begin
            a = (st + i) % 256;
            if (wr && a < FUSE_WORDS) fuse[a] = fuse[a] | dreg[i];
            else if (!wr) dreg[i] = (a < FUSE_WORDS) ? fuse[a] : 0;
        end
        if (wr) wr_end = 1'b1;
        else rd_end = 1'b1;
        chk_reg("ctrl done", {8'h00, 2'b00, rd_end, 3'b000, wr_end, 1'b0}, rd_v);
        for (int i = 0; i < n; i++) begin
            fms_host_model_i.rd(OFS_DATA_BASE + 16'(2 * i), rd_v);
            chk_reg("data word", 16'(dreg[i]), rd_v);
        end
        $display("test sequence wr=%0d start=%0d len=%0d done", wr, st, n);
    endtask : run_seq

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        seed = 32'h87b7_f33e;
        rst = 1'b1;
        fails = 0;
        check_count = 0;
        cyc = 0;
        wr_end = 1'b0;
        rd_end = 1'b0;
        foreach (fuse[i]) fuse[i] = 0;
        foreach (dreg[i]) dreg[i] = 0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk_pin("standby", 1'b1, soft_standby);
        chk_pin("busy", 1'b0, fuse_busy);
        for (int i = 0; i < 10; i++) begin
            fms_host_model_i.rd(regs[i], rd_v);
            chk_reg("reset value", 16'h0000, rd_v);
        end
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            v = 16'($random(seed));
            if (i == 7) v[0] = 1'b0;
            fms_host_model_i.wr(regs[i], v);
            fms_host_model_i.rd(regs[i], rd_v);
            chk_reg("register", v & msk[i], rd_v & (msk[i] | (i > 6 ? 16'hffff : 16'h0000)));
            if (i == 6) dreg[1] = int'(v);
        end
        fms_host_model_i.rd(OFS_RUN_CTRL, rd_v);
        chk_pin("stream", rd_v[RUN_STREAM_BIT], core_clk_en);
        $display("test register access done");
        fms_host_model_i.wr(OFS_SW_RESET, 16'h0001);
        fms_host_model_i.wr(OFS_SEQ_CTRL, 16'h0001);
        fms_host_model_i.rd(OFS_SEQ_CTRL, rd_v);
        chk_reg("refused start", 16'h0000, rd_v);
        fms_host_model_i.rd(OFS_DATA_BASE + 16'h0002, rd_v);
        chk_reg("window kept", 16'(dreg[1]), rd_v);
        $display("test soft reset done");
        fms_host_model_i.wr(OFS_RUN_CTRL, 16'h10d8);
        chk_pin("standby", 1'b1, soft_standby);
        fms_host_model_i.wr(OFS_PLL, 16'h0200);
        chk_pin("bypass", 1'b1, pll_bypass);
        fms_host_model_i.wr(OFS_MODE, 16'h0100);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 3 - b; i++) begin
                dreg[i] = int'(16'($random(seed)));
                fms_host_model_i.wr(OFS_DATA_BASE + 16'(2 * i), 16'(dreg[i]));
            end
            run_seq(1'b1, b ? 128 : 248, 3 - b);
        end
        fms_host_model_i.wr(OFS_SW_RESET, 16'h0001);
        wr_end = 1'b0;
        fms_host_model_i.wr(OFS_MODE, 16'h0100);
        run_seq(1'b0, 248, 3);
        run_seq(1'b0, 128, 2);
        report_and_stop();
    end
endmodule : tb_fuse_memory_auto_sequencer
